//--- alu_if.sv
// Signals between the decoder core and its ALU
`timescale 1ns/100ps
interface alu_if;
  insn_decode_pkg::alu_op_t op;
  logic [7:0]               opnd;
  logic [7:0]               w;
  logic [2:0]               bsel;
  logic                     c_in;
  logic [7:0]               res;
  logic                     c_out;
  logic                     dc_out;
  logic                     upd_c;
  logic                     upd_dc;
  logic                     upd_z;
  modport core (output op, opnd, w, bsel, c_in,
                input  res, c_out, dc_out, upd_c, upd_dc, upd_z);
  modport unit (input  op, opnd, w, bsel, c_in,
                output res, c_out, dc_out, upd_c, upd_dc, upd_z);
endinterface // alu_if

//--- alu_unit.sv
// Eight-bit ALU with carry, digit carry and zero update marks
`timescale 1ns/100ps
module alu_unit (
  // Operands and results
  alu_if.unit u
);
  // Single set bit, shifted into place for bit clear and bit set
  localparam logic [7:0] BIT_ONE_V = insn_decode_pkg::BIT_ONE;

  logic [7:0] addend;
  logic       cin;
  logic [8:0] sum;
  logic [4:0] nib;

  // Shared adder: subtract is add of complement plus one
  always_comb
  begin
    addend   = u.w;
    cin      = 1'b0;
    u.res    = u.opnd;
    u.c_out  = u.c_in;
    u.dc_out = 1'b0;
    u.upd_c  = 1'b0;
    u.upd_dc = 1'b0;
    u.upd_z  = 1'b0;
    if (u.op == insn_decode_pkg::OP_SUB || u.op == insn_decode_pkg::OP_SUBB)
      addend = ~u.w;
    if (u.op == insn_decode_pkg::OP_SUB)
      cin = 1'b1;
    else if (u.op == insn_decode_pkg::OP_SUBB ||
             u.op == insn_decode_pkg::OP_ADDC)
      cin = u.c_in;  // Borrow is the inverted carry
    sum = {1'b0, u.opnd} + {1'b0, addend} + {8'h00, cin};
    nib = {1'b0, u.opnd[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
    case (u.op)
      insn_decode_pkg::OP_ADD, insn_decode_pkg::OP_ADDC,
      insn_decode_pkg::OP_SUB, insn_decode_pkg::OP_SUBB:
      begin
        u.res    = sum[7:0];
        u.c_out  = sum[8];
        u.dc_out = nib[4];
        u.upd_c  = 1'b1;
        u.upd_dc = 1'b1;
        u.upd_z  = 1'b1;
      end
      insn_decode_pkg::OP_MOV: u.upd_z = 1'b1;
      insn_decode_pkg::OP_CLR:
      begin
        u.res   = 8'h00;
        u.upd_z = 1'b1;
      end
      insn_decode_pkg::OP_AND:
      begin
        u.res   = u.opnd & u.w;
        u.upd_z = 1'b1;
      end
      insn_decode_pkg::OP_IOR:
      begin
        u.res   = u.opnd | u.w;
        u.upd_z = 1'b1;
      end
      insn_decode_pkg::OP_XOR:
      begin
        u.res   = u.opnd ^ u.w;
        u.upd_z = 1'b1;
      end
      insn_decode_pkg::OP_COM:
      begin
        u.res   = ~u.opnd;
        u.upd_z = 1'b1;
      end
      insn_decode_pkg::OP_INC:
      begin
        u.res   = u.opnd + 8'h01;
        u.upd_z = 1'b1;
      end
      insn_decode_pkg::OP_DEC:
      begin
        u.res   = u.opnd - 8'h01;
        u.upd_z = 1'b1;
      end
      insn_decode_pkg::OP_RLF, insn_decode_pkg::OP_LSL:
      begin
        u.res   = {u.opnd[6:0],
                   u.op == insn_decode_pkg::OP_RLF ? u.c_in : 1'b0};
        u.c_out = u.opnd[7];
        u.upd_c = 1'b1;
        u.upd_z = (u.op == insn_decode_pkg::OP_LSL);
      end
      insn_decode_pkg::OP_RRF, insn_decode_pkg::OP_LSR,
      insn_decode_pkg::OP_ASR:
      begin
        u.res   = {u.op == insn_decode_pkg::OP_RRF ? u.c_in :
                   u.op == insn_decode_pkg::OP_ASR ? u.opnd[7] : 1'b0,
                   u.opnd[7:1]};
        u.c_out = u.opnd[0];
        u.upd_c = 1'b1;
        u.upd_z = (u.op != insn_decode_pkg::OP_RRF);
      end
      insn_decode_pkg::OP_SWAP:  u.res = {u.opnd[3:0], u.opnd[7:4]};
      insn_decode_pkg::OP_BCF:   u.res = u.opnd & ~(BIT_ONE_V << u.bsel);
      insn_decode_pkg::OP_BSF:   u.res = u.opnd | (BIT_ONE_V << u.bsel);
      insn_decode_pkg::OP_PASSW: u.res = u.w;
      default:                   u.res = u.opnd;
    endcase
  end
endmodule // alu_unit

//--- insn_decode_pkg.sv
// Shared constants and types for the instruction decoder and its ALU
package insn_decode_pkg;
  // Widths
  localparam int WORD_W  = 14;
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 7;
  // Oscillator cycles per instruction cycle, one per phase below
  localparam int OSC_PER_INSN = 4;
  // Reset values, extra-cycle counts and the single-bit mask
  localparam logic [13:0] RST_WORD = 14'h0000;
  localparam logic [7:0]  RST_DATA = 8'h00;
  localparam logic [1:0]  EXTRA_NONE = 2'h0;
  localparam logic [1:0]  EXTRA_ONE  = 2'h1;
  localparam logic [7:0]  BIT_ONE    = 8'h01;
  // Opcode top bits <13:12>
  localparam logic [1:0] TOP_BYTE = 2'h0;
  localparam logic [1:0] TOP_BIT  = 2'h1;
  localparam logic [1:0] TOP_LIT  = 2'h3;
  // Byte group <11:8> under TOP_BYTE
  localparam logic [3:0] B_MOVWF = 4'h0, B_CLR = 4'h1, B_SUB = 4'h2;
  localparam logic [3:0] B_DEC = 4'h3, B_IOR = 4'h4, B_AND = 4'h5;
  localparam logic [3:0] B_XOR = 4'h6, B_ADD = 4'h7, B_MOV = 4'h8;
  localparam logic [3:0] B_COM = 4'h9, B_INC = 4'hA, B_DECSZ = 4'hB;
  localparam logic [3:0] B_RRF = 4'hC, B_RLF = 4'hD, B_SWAP = 4'hE;
  localparam logic [3:0] B_INCSZ = 4'hF;
  // Group <11:8> under TOP_LIT, literal and extended byte operations
  localparam logic [3:0] L_MOVLW = 4'h0, L_SUBROUTINE_EXIT_WITH_LITERAL = 4'h4, X_LSL = 4'h5;
  localparam logic [3:0] X_LSR = 4'h6, X_ASR = 4'h7, L_IOR = 4'h8;
  localparam logic [3:0] L_AND = 4'h9, L_XOR = 4'hA, X_SUBB = 4'hB;
  localparam logic [3:0] L_SUB = 4'hC, X_ADDC = 4'hD, L_ADD = 4'hE;
  // Bit group <11:10>
  localparam logic [1:0] BIT_CLR = 2'h0, BIT_SET = 2'h1;
  // Control space prefixes
  localparam logic [6:0]  CTL0_HI    = 7'h00;   // word<13:7>
  localparam logic [9:0]  IND_MV_HI  = 10'h001; // word<13:4>
  localparam logic [11:0] RET_GRP_HI = 12'h002; // word<13:2>
  localparam logic [1:0]  RG_SUBROUTINE_INVOKE_BY_ACC   = 2'h2;
  localparam logic [1:0]  RG_BRW     = 2'h3;
  localparam logic [2:0]  CALL_HI    = 3'h4;    // word<13:11>
  localparam logic [2:0]  ABSOLUTE_JUMP_HI    = 3'h5;
  localparam logic [4:0]  BRA_HI     = 5'h19;   // word<13:9>
  // Indirect access registers sit at file addresses 0 and 1
  localparam logic [5:0]  IND_PAIR_HI = 6'h00;
  // Phase sequencer, one-hot
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1, PH_Q2 = 4'h2, PH_Q3 = 4'h4, PH_Q4 = 4'h8
  } phase_t;
  typedef enum logic [1:0] {
    CLS_BYTE = 2'h0, CLS_BIT = 2'h1, CLS_CTRL = 2'h2
  } insn_class_t;
  typedef enum logic [4:0] {
    OP_NONE, OP_MOV, OP_CLR, OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND,
    OP_IOR, OP_XOR, OP_COM, OP_INC, OP_DEC, OP_RLF, OP_RRF, OP_LSL,
    OP_LSR, OP_ASR, OP_SWAP, OP_BCF, OP_BSF, OP_PASSW
  } alu_op_t;
endpackage

//--- insn_decode_timing.sv
// Instruction decoder, phase sequencer and cycle timing of the core
// Functional notes
// RULE_01: Every instruction is one 14-bit word holding opcode and operands.
// RULE_02: Opcodes fall into byte, bit and literal/control groups.
// RULE_03: Instructions take one instruction cycle unless listed below.
// RULE_04: Direct call and call through accumulator take two cycles.
// RULE_05: Return, return with literal and interrupt exit take two cycles.
// RULE_06: Jumps, branches and taken skips take two cycles.
// RULE_07: Indirect access pointing into program memory adds one cycle.
// RULE_08: One instruction cycle is four oscillator cycles.
// RULE_09: File operands are always read before the result is stored.
// RULE_10: File address field spans 0x00 to 0x7F in the current bank.
// RULE_11: Bit field picks one bit of the addressed 8-bit register.
// RULE_12: Destination bit 0 stores to accumulator, 1 to file register.
// RULE_13: Don't-care opcode bits are ignored, either value accepted.
// RULE_14: Pointer number field selects indirect pointer pair 0 or 1.
// RULE_15: Mode field picks pre/post increment or decrement of pointer.
// RULE_16: Conditional skip costs two cycles only when the skip is taken.
// RULE_17: Carry, digit carry and zero flags update as each op defines.
`timescale 1ns/100ps
module insn_decode_timing (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Program memory
  input  wire logic [13:0] instr_word,
  output      logic        fetch,
  // File register port
  output      logic [6:0]  file_addr,
  output      logic        file_rd,
  input  wire logic [7:0]  file_rdata,
  output      logic        file_wr,
  output      logic [7:0]  file_wdata,
  // Indirect pointers
  input  wire logic [1:0]  ind_in_prog,
  output      logic        ptr_sel,
  output      logic        ptr_adj,
  output      logic        ptr_dec,
  // Core state
  output      logic [7:0]  acc,
  output      logic        carry,
  output      logic        digit_carry_flag,
  output      logic        zero,
  output      logic [1:0]  insn_class,
  output      logic        flush
);
  typedef struct packed {
    insn_decode_pkg::phase_t phase;
    logic [1:0]  extra;
    logic [13:0] ir;
    logic [7:0]  rd;
    logic [7:0]  acc;
    logic        c;
    logic        dc;
    logic        z;
    logic        wr;
    logic [7:0]  wdata;
  } state_t;

  state_t st;
  state_t next_st;
  alu_if  alu_bus ();

  logic [1:0] top;
  logic [3:0] sub;
  logic       dbit;
  logic       is_ctl0, is_byte, is_bit, is_lit_x, is_ind_mv, is_rgrp;
  logic       uses_file, indirect, ptr_n, ind_extra;
  logic       wr_w, wr_f, skip_op, skip_taken, flag_en;
  logic       is_call, is_ret, is_jump, two_cyc, commit;
  insn_decode_pkg::alu_op_t op;

  alu_unit u_alu (
    .u (alu_bus)
  );

  // Field split of the held word; low don't-care bits never compared
  assign top  = st.ir[13:12];                                // RULE_01
  assign sub  = st.ir[11:8];
  assign dbit = st.ir[7];
  assign is_ctl0   = (st.ir[13:7] == insn_decode_pkg::CTL0_HI); // RULE_13
  assign is_ind_mv = (st.ir[13:4] == insn_decode_pkg::IND_MV_HI);
  assign is_rgrp   = (st.ir[13:2] == insn_decode_pkg::RET_GRP_HI);
  assign is_lit_x  = (top == insn_decode_pkg::TOP_LIT) &&
                     (sub == insn_decode_pkg::X_LSL ||
                      sub == insn_decode_pkg::X_LSR ||
                      sub == insn_decode_pkg::X_ASR ||
                      sub == insn_decode_pkg::X_SUBB ||
                      sub == insn_decode_pkg::X_ADDC);
  // Three opcode groups
  assign is_byte = ((top == insn_decode_pkg::TOP_BYTE) && !is_ctl0) ||
                   is_lit_x;                                 // RULE_02
  assign is_bit  = (top == insn_decode_pkg::TOP_BIT);        // RULE_02
  assign insn_class = is_byte ? insn_decode_pkg::CLS_BYTE :
                      is_bit  ? insn_decode_pkg::CLS_BIT  :
                                insn_decode_pkg::CLS_CTRL;   // RULE_02
  assign uses_file = is_byte || is_bit || is_ind_mv;

  // Indirect access and pointer pair choice
  assign indirect  = is_ind_mv ||
    (uses_file && st.ir[6:1] == insn_decode_pkg::IND_PAIR_HI);
  assign ptr_n     = is_ind_mv ? st.ir[2] : st.ir[0];        // RULE_14
  assign ind_extra = indirect && ind_in_prog[ptr_n];         // RULE_07

  // Flow control groups
  assign is_call = (st.ir[13:11] == insn_decode_pkg::CALL_HI) ||
                   (is_rgrp && st.ir[1:0] == insn_decode_pkg::RG_SUBROUTINE_INVOKE_BY_ACC);
  assign is_ret  = (is_rgrp && !st.ir[1]) ||
                   (top == insn_decode_pkg::TOP_LIT &&
                    sub == insn_decode_pkg::L_SUBROUTINE_EXIT_WITH_LITERAL);
  assign is_jump = (st.ir[13:11] == insn_decode_pkg::ABSOLUTE_JUMP_HI) ||
                   (st.ir[13:9] == insn_decode_pkg::BRA_HI) ||
                   (is_rgrp && st.ir[1:0] == insn_decode_pkg::RG_BRW);
  assign skip_op = (top == insn_decode_pkg::TOP_BYTE && !is_ctl0 &&
                    (sub == insn_decode_pkg::B_DECSZ ||
                     sub == insn_decode_pkg::B_INCSZ)) ||
                   (is_bit && st.ir[11]);
  // Bit tests compare the selected bit with the wanted polarity
  assign skip_taken = skip_op && (is_bit ?
    (st.rd[st.ir[9:7]] == st.ir[10]) :                       // RULE_11
    (alu_bus.res == insn_decode_pkg::RST_DATA));             // RULE_16
  assign two_cyc = is_call || is_ret || is_jump ||
                   skip_taken;                    // RULE_04 RULE_05 RULE_06

  // Destination steering
  assign wr_w = (is_byte && !dbit) || (is_ind_mv && !st.ir[3]) ||
                (top == insn_decode_pkg::TOP_LIT && !is_lit_x &&
                 (sub == insn_decode_pkg::L_MOVLW ||
                  sub == insn_decode_pkg::L_SUBROUTINE_EXIT_WITH_LITERAL ||
                  sub[3]));                                  // RULE_12
  assign wr_f = (is_byte && dbit) || (is_ind_mv && st.ir[3]) ||
                (is_bit && !st.ir[11]);                      // RULE_12
  // Skip forms leave the flags alone; loads through OP_MOV still update zero
  assign flag_en = !skip_op;

  // Opcode to ALU operation
  always_comb
  begin
    op = insn_decode_pkg::OP_NONE;
    if (is_ind_mv)
      op = st.ir[3] ? insn_decode_pkg::OP_PASSW : insn_decode_pkg::OP_MOV;
    else if (is_bit)
      op = (st.ir[11:10] == insn_decode_pkg::BIT_CLR) ?
             insn_decode_pkg::OP_BCF :
           (st.ir[11:10] == insn_decode_pkg::BIT_SET) ?
             insn_decode_pkg::OP_BSF : insn_decode_pkg::OP_NONE;
    else if (top == insn_decode_pkg::TOP_BYTE && !is_ctl0)
      case (sub)
        insn_decode_pkg::B_MOVWF: op = dbit ? insn_decode_pkg::OP_PASSW :
                                             insn_decode_pkg::OP_NONE;
        insn_decode_pkg::B_CLR:   op = insn_decode_pkg::OP_CLR;
        insn_decode_pkg::B_SUB:   op = insn_decode_pkg::OP_SUB;
        insn_decode_pkg::B_DEC,
        insn_decode_pkg::B_DECSZ: op = insn_decode_pkg::OP_DEC;
        insn_decode_pkg::B_IOR:   op = insn_decode_pkg::OP_IOR;
        insn_decode_pkg::B_AND:   op = insn_decode_pkg::OP_AND;
        insn_decode_pkg::B_XOR:   op = insn_decode_pkg::OP_XOR;
        insn_decode_pkg::B_ADD:   op = insn_decode_pkg::OP_ADD;
        insn_decode_pkg::B_MOV:   op = insn_decode_pkg::OP_MOV;
        insn_decode_pkg::B_COM:   op = insn_decode_pkg::OP_COM;
        insn_decode_pkg::B_INC,
        insn_decode_pkg::B_INCSZ: op = insn_decode_pkg::OP_INC;
        insn_decode_pkg::B_RRF:   op = insn_decode_pkg::OP_RRF;
        insn_decode_pkg::B_RLF:   op = insn_decode_pkg::OP_RLF;
        default:                  op = insn_decode_pkg::OP_SWAP;
      endcase
    else if (top == insn_decode_pkg::TOP_LIT)
      case (sub)
        insn_decode_pkg::X_LSL:  op = insn_decode_pkg::OP_LSL;
        insn_decode_pkg::X_LSR:  op = insn_decode_pkg::OP_LSR;
        insn_decode_pkg::X_ASR:  op = insn_decode_pkg::OP_ASR;
        insn_decode_pkg::X_SUBB: op = insn_decode_pkg::OP_SUBB;
        insn_decode_pkg::X_ADDC: op = insn_decode_pkg::OP_ADDC;
        insn_decode_pkg::L_IOR:  op = insn_decode_pkg::OP_IOR;
        insn_decode_pkg::L_AND:  op = insn_decode_pkg::OP_AND;
        insn_decode_pkg::L_XOR:  op = insn_decode_pkg::OP_XOR;
        insn_decode_pkg::L_SUB:  op = insn_decode_pkg::OP_SUB;
        insn_decode_pkg::L_ADD:  op = insn_decode_pkg::OP_ADD;
        default:                 op = insn_decode_pkg::OP_NONE;
      endcase
  end

  // ALU operands: file value for file groups, literal otherwise
  assign alu_bus.op   = op;
  assign alu_bus.opnd = uses_file ? st.rd : st.ir[7:0];
  assign alu_bus.w    = st.acc;
  assign alu_bus.bsel = st.ir[9:7];                          // RULE_11
  assign alu_bus.c_in = st.c;

  // Handshake outputs; file read happens in Q3 of every file op
  assign commit    = (st.phase == insn_decode_pkg::PH_Q4) &&
                     (st.extra == insn_decode_pkg::EXTRA_NONE);
  assign fetch     = (st.phase == insn_decode_pkg::PH_Q4);
  assign file_rd   = (st.phase == insn_decode_pkg::PH_Q3) && uses_file &&
                     (st.extra == insn_decode_pkg::EXTRA_NONE); // RULE_09
  assign file_addr = is_ind_mv ? {insn_decode_pkg::IND_PAIR_HI, st.ir[2]} :
                                 st.ir[6:0];                 // RULE_10
  assign ptr_sel   = ptr_n;
  // Pre-modes adjust in Q2 before the read, post-modes in Q4 after it
  assign ptr_adj   = is_ind_mv &&
                     (st.extra == insn_decode_pkg::EXTRA_NONE) &&
    ((st.phase == insn_decode_pkg::PH_Q2 && !st.ir[1]) ||
     (st.phase == insn_decode_pkg::PH_Q4 && st.ir[1]));      // RULE_15
  assign ptr_dec   = st.ir[0];                               // RULE_15
  assign flush     = (st.extra != insn_decode_pkg::EXTRA_NONE);
  assign file_wr   = st.wr;
  assign file_wdata = st.wdata;
  assign acc       = st.acc;
  assign carry     = st.c;
  assign digit_carry_flag = st.dc;
  assign zero      = st.z;

  // Four-phase sequencer; extra cycles run the phases with no work
  always_comb
  begin
    next_st = st;
    case (st.phase)
      insn_decode_pkg::PH_Q1:
      begin
        next_st.phase = insn_decode_pkg::PH_Q2;              // RULE_08
        next_st.wr    = 1'b0;
        if (st.extra == insn_decode_pkg::EXTRA_NONE)
          next_st.ir = instr_word;                           // RULE_01
      end
      insn_decode_pkg::PH_Q2: next_st.phase = insn_decode_pkg::PH_Q3;
      insn_decode_pkg::PH_Q3:
      begin
        next_st.phase = insn_decode_pkg::PH_Q4;
        if (file_rd)
          next_st.rd = file_rdata;                           // RULE_09
      end
      insn_decode_pkg::PH_Q4:
      begin
        next_st.phase = insn_decode_pkg::PH_Q1;
        if (!commit)
          next_st.extra = st.extra - insn_decode_pkg::EXTRA_ONE;
        else
        begin
          next_st.extra = {1'b0, two_cyc} + {1'b0, ind_extra}; // RULE_03
          if (wr_w)
            next_st.acc = alu_bus.res;                       // RULE_12
          if (wr_f)
          begin
            next_st.wr    = 1'b1;
            next_st.wdata = alu_bus.res;
          end
          if (flag_en && alu_bus.upd_c)
            next_st.c = alu_bus.c_out;                       // RULE_17
          if (flag_en && alu_bus.upd_dc)
            next_st.dc = alu_bus.dc_out;                     // RULE_17
          if (flag_en && alu_bus.upd_z)
            next_st.z = (alu_bus.res == insn_decode_pkg::RST_DATA);
        end
      end
      default: next_st.phase = insn_decode_pkg::PH_Q1;
    endcase
  end

  // State register; reset starts at Q1 with a cleared word
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '{phase: insn_decode_pkg::PH_Q1,
              extra: insn_decode_pkg::EXTRA_NONE,
              ir: insn_decode_pkg::RST_WORD,
              rd: insn_decode_pkg::RST_DATA,
              acc: insn_decode_pkg::RST_DATA,
              c: 1'b0, dc: 1'b0, z: 1'b0, wr: 1'b0,
              wdata: insn_decode_pkg::RST_DATA};
    else
      st <= next_st;
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rest_of_insn;
    st.phase == insn_decode_pkg::PH_Q2 ##1
    st.phase == insn_decode_pkg::PH_Q3 ##1
    st.phase == insn_decode_pkg::PH_Q4;
  endsequence
  sequence s_one_extra;
    flush [*4] ##1 !flush;
  endsequence

  property p_phase;
    st.phase == insn_decode_pkg::PH_Q1 |=> s_rest_of_insn ##1
      st.phase == insn_decode_pkg::PH_Q1;
  endproperty
  a_phase: assert property (p_phase) else $error("phase order"); // RULE_08

  property p_rmw;
    file_wr |-> $past(file_rd, 2);
  endproperty
  a_rmw: assert property (p_rmw) else $error("write not read"); // RULE_09

  property p_read_all;
    commit && uses_file |-> $past(file_rd);
  endproperty
  a_read_all: assert property (p_read_all)
    else $error("file op skipped its read"); // RULE_09

  property p_dest_w;
    commit && is_byte && !dbit |=> !file_wr && acc == $past(alu_bus.res);
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("d=0 path"); // RULE_12

  property p_dest_f;
    commit && is_byte && dbit |=> file_wr &&
      file_wdata == $past(alu_bus.res) && acc == $past(st.acc);
  endproperty
  a_dest_f: assert property (p_dest_f) else $error("d=1 path"); // RULE_12

  property p_call;
    commit && is_call && !ind_extra |=> s_one_extra;
  endproperty
  a_call: assert property (p_call) else $error("call length"); // RULE_04

  property p_ret;
    commit && is_ret |=> s_one_extra;
  endproperty
  a_ret: assert property (p_ret) else $error("return length"); // RULE_05

  property p_jump;
    commit && is_jump |=> s_one_extra;
  endproperty
  a_jump: assert property (p_jump) else $error("branch length"); // RULE_06

  property p_skip;
    commit && skip_op && !ind_extra |=> flush == $past(skip_taken);
  endproperty
  a_skip: assert property (p_skip) else $error("skip length"); // RULE_16

  property p_single;
    commit && !two_cyc && !ind_extra |=> !flush;
  endproperty
  a_single: assert property (p_single) else $error("one cycle"); // RULE_03

  property p_ind;
    commit && ind_extra && !two_cyc |=> s_one_extra;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect extra"); // RULE_07

  property p_zero;
    commit && flag_en && alu_bus.upd_z |=>
      zero == ($past(alu_bus.res) == insn_decode_pkg::RST_DATA);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag"); // RULE_17
endmodule // insn_decode_timing

//--- insn_decode_timing_tb_top.sv
// Self-checking bench for the instruction decoder timing
`timescale 1ns/100ps
module insn_decode_timing_tb_top;
  // Per instruction k: extra cycle, file read of k+1, file write of k
  localparam logic [13:0] EXP_X  = 14'h0BFC;
  localparam logic [13:0] EXP_RD = 14'h1F01;
  localparam logic [13:0] EXP_WR = 14'h0002;
  localparam logic [13:0] PROG [0:14] = '{14'h305A, 14'h00A0, 14'h2000,
    14'h0008, 14'h0009, 14'h000A, 14'h000B, 14'h2800, 14'h3200, 14'h1C21,
    14'h1821, 14'h0010, 14'h0014, 14'h0103, 14'h0000};
  logic        ref_clk;
  logic        rst_n;
  logic [13:0] instr_word;
  logic        fetch;
  logic [6:0]  file_addr;
  logic        file_rd;
  logic [7:0]  file_rdata;
  logic        file_wr;
  logic [7:0]  file_wdata;
  logic [1:0]  ind_in_prog;
  logic        carry;
  logic        digit_carry_flag;
  logic        zero;
  logic        flush;
  logic [7:0]  acc;
  logic        ptr_sel;
  logic        ptr_adj;
  logic        ptr_dec;
  logic [1:0]  insn_class;
  int          error_cnt;
  int          checked;

  insn_decode_timing insn_decode_timing_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .instr_word(instr_word), .fetch(fetch),
    .file_addr(file_addr), .file_rd(file_rd), .file_rdata(file_rdata),
    .file_wr(file_wr), .file_wdata(file_wdata), .ind_in_prog(ind_in_prog),
    .ptr_sel(ptr_sel), .ptr_adj(ptr_adj), .ptr_dec(ptr_dec), .acc(acc),
    .carry(carry), .digit_carry_flag(digit_carry_flag), .zero(zero),
    .insn_class(insn_class),
    .flush(flush));
  prog_mem_model prog_mem_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .fetch(fetch), .flush(flush), .instr_word(instr_word));

  // Free-running oscillator clock
  always #2 ref_clk = ~ref_clk;

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Quiet outputs while reset is held
  task automatic check_reset_state();
    check("reset_acc", {8'h00, acc}, 16'h0000);
    check("reset_ctl", {11'h000, carry, zero, flush, file_wr, file_rd},
          16'h0000);
  endtask

  // Runs the program; each window runs from one commit to the next
  task automatic check_program_timing();
    int c;
    int fl;
    int rd;
    int wr;
    int pa;
    pa = 0;
    for (int k = 0; k < 15; k++)
    begin
      c = 0;
      fl = 0;
      rd = 0;
      wr = 0;
      do
      begin
        @(posedge ref_clk);
        #1;
        c++;
        fl += (flush === 1'b1);
        rd += (file_rd === 1'b1);
        wr += (file_wr === 1'b1);
        pa += (ptr_adj === 1'b1);
        if (file_wr === 1'b1)
          check("wdata", {8'h00, file_wdata}, 16'h005A);
        if (k == 1 && c == 1)
          check("acc_lit", {8'h00, acc}, 16'h005A);
      end
      while (!(fetch === 1'b1 && flush === 1'b0) && c < 40);
      if (c >= 40)
      begin
        error_cnt++;
        tally_and_finish();
      end
      if (k > 0)
      begin
        check("base", 16'(c - fl), 16'(insn_decode_pkg::OSC_PER_INSN));
        check("extra", 16'(fl), 16'(EXP_X[k-1] * 4));
        check("read", 16'(rd), {15'h0000, EXP_RD[k-1]});
        check("write", 16'(wr), {15'h0000, EXP_WR[k-1]});
      end
      if (k == 9)
        check("class", {14'h0000, insn_class}, 16'h0001);
      if (k == 12)
        check("ptr", {14'h0000, ptr_sel, ptr_dec}, 16'h0002);
    end
    check("acc_clr", {8'h00, acc}, 16'h0000);
    check("ptr_adj", 16'(pa), 16'h0002);
    check("flags", {13'h0000, zero, carry, digit_carry_flag},
          16'h0004);
  endtask

  // Main sequence: program load, reset, timing run
  initial
  begin
    error_cnt = 0;
    checked = 0;
    ref_clk = 1'b0;
    rst_n <= 1'b0;
    file_rdata <= 8'h01;
    ind_in_prog <= 2'h1;
    for (int i = 0; i < 15; i++)
      prog_mem_model_inst.mem[i] = PROG[i];
    repeat (3) @(posedge ref_clk);
    #1;
    check_reset_state();
    @(posedge ref_clk);
    rst_n <= 1'b1;
    check_program_timing();
    tally_and_finish();
  end
endmodule // insn_decode_timing_tb_top

//--- prog_mem_model.sv
// Program memory model that hands one word per instruction to the core
`timescale 1ns/100ps
module prog_mem_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Core side
  input  wire logic        fetch,
  input  wire logic        flush,
  output      logic [13:0] instr_word
);
  logic [13:0] mem [0:15];
  logic [3:0]  ptr;

  // Always one whole 14-bit word on the bus; flush fetches do not advance
  assign instr_word = mem[ptr];
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ptr <= 4'h0;
    else if (fetch && !flush)
      ptr <= ptr + 4'h1;
  end
endmodule // prog_mem_model
